// ===== deadline_timer.v
// Purpose: loadable down-counter reporting expiry
// Assumes: one clock domain
// Notes: load has priority over counting
`timescale 1ns/10ps
module deadline_timer (
   input wire clk,
   input wire rst,
   input wire load,
   input wire [31:0] count,
   output reg busy,
   output reg done
);
   reg [31:0] cnt_reg;

   // ==========================================================
   // count down, single-cycle done once the count reaches one
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 32'h0000_0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         cnt_reg <= count;
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy && cnt_reg <= 32'h0000_0001) begin
         busy <= 1'b0;
         done <= 1'b1;
      end else begin
         cnt_reg <= busy ? cnt_reg - 32'h0000_0001 : cnt_reg;
         done <= 1'b0;
      end
   end
endmodule // deadline_timer

// ===== host_pins.sv
// Purpose: host side of the module control pins
// Assumes: pins change just after a rising edge
// Notes: pins are always driven, never floated
`timescale 1ns/10ps
module host_pins (
   input wire clk,
   output logic off_req,
   output logic rx_sel,
   output logic tx_sel
);
// ==========================================
// pin drivers; each task ends 1 ns past the edge
initial begin
   off_req = 1'b0;
   rx_sel = 1'b0;
   tx_sel = 1'b0;
end
task automatic set_off(input logic v);
   @(posedge clk);
   off_req <= v;
   #1;
endtask
// fault reset: request held high n cycles
task automatic pulse(input int n);
   @(posedge clk);
   off_req <= 1'b1;
   repeat (n) @(posedge clk);
   off_req <= 1'b0;
   #1;
endtask
task automatic set_sel(input logic r, input logic t);
   @(posedge clk);
   rx_sel <= r;
   tx_sel <= t;
   #1;
endtask
endmodule // host_pins

// ===== optmod_ctrl.v
// Purpose: module-side control and status pin timing
// Assumes: host pins are asynchronous, 100 MHz clock
// Notes: analog actions modelled as laser/rate/status outputs
//
// Operation
// - laser off within 100 us of disable
// - laser on within 2 ms normally
// - management ready within 300 ms
// - fully operational within 300 ms
// - no power level II or cooled behaviour
// - fault flag within 1 ms of fault
// - disable high 10 us resets fault
// - rate settles in 500 us for FC
// - rate settles in 10 ms otherwise
// - signal-lost flag within 100 us
// - signal-lost clears within 100 us
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "optmod_defines.vh"
module optmod_ctrl #(
   parameter [31:0] START_CYCLES = `CYC_START,
   parameter [31:0] MGMT_CYCLES = `CYC_MGMT,
   parameter [31:0] FAULT_CYCLES = `CYC_FAULT,
   parameter [31:0] ON_CYCLES = `CYC_ON,
   parameter [31:0] RATE_NFC_CYCLES = `CYC_RATE_NFC,
   parameter [31:0] RATE_FC_CYCLES = `CYC_RATE_FC,
   parameter [31:0] OFF_CYCLES = `CYC_OFF,
   parameter [31:0] LOS_CYCLES = `CYC_LOS,
   parameter [31:0] RESET_CYCLES = `CYC_RESET
) (
   input wire CLK,
   input wire RST,
   input wire LASER_OFF_REQ,
   input wire RECEIVE_BANDWIDTH_SELECT,
   input wire TRANSMIT_BANDWIDTH_SELECT,
   output reg TX_FAULT,
   output reg RX_SIGNAL_LOST,
   output reg LASER_ON,
   output reg MGMT_READY,
   output reg OPERATIONAL,
   output reg RX_HIGH_BW,
   output reg TX_HIGH_BW,
   output reg IRQ,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR
);
   // states of the transmitter; one-hot
   localparam [3:0] ST_START = 4'b0001;
   localparam [3:0] ST_RUN = 4'b0010;
   localparam [3:0] ST_OFF = 4'b0100;
   localparam [3:0] ST_FAULT = 4'b1000;

   reg [1:0] dis_sync_reg, rs0_sync_reg, rs1_sync_reg;
   reg dis_prev_reg, rs0_prev_reg, rs1_prev_reg;
   reg [3:0] state_reg;
   reg [31:0] ctrl_reg;
   reg [`EV_N-1:0] ev_stat_reg, ev_en_reg;
   reg [31:0] hold_cnt_reg;
   reg [31:0] flt_cnt_reg, los_cnt_reg, off_cnt_reg, on_cnt_reg;
   reg los_state_reg, ramping_reg, rate_busy_reg;
   reg [31:0] rate_cnt_reg;
   wire dis_s, rs0_s, rs1_s;
   wire dis_rise, dis_fall, rate_chg;
   wire fc_mode, fault_cond, sig_present;
   wire mgmt_busy, mgmt_done, start_busy, start_done;
   wire fault_reset;
   wire apb_wr, apb_rd;
   wire [`EV_N-1:0] ev_set;
   reg [31:0] rd_mux;

   assign dis_s = dis_sync_reg[1];
   assign rs0_s = rs0_sync_reg[1];
   assign rs1_s = rs1_sync_reg[1];
   assign dis_rise = dis_s & ~dis_prev_reg;
   assign dis_fall = ~dis_s & dis_prev_reg;
   assign rate_chg = (rs0_s ^ rs0_prev_reg) | (rs1_s ^ rs1_prev_reg);
   assign fc_mode = ctrl_reg[`CTRL_FC];
   assign fault_cond = ctrl_reg[`CTRL_FAULT_IN];
   assign sig_present = ctrl_reg[`CTRL_SIG_IN];
   assign apb_wr = PSEL & PENABLE & PWRITE & PREADY;
   assign apb_rd = PSEL & ~PENABLE & ~PWRITE;
   // fault reset needs disable held high long enough
   assign fault_reset = dis_s && hold_cnt_reg >= RESET_CYCLES;

   // ==========================================================
   // pin synchronisers, two flops each
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         dis_sync_reg <= 2'b11;
         rs0_sync_reg <= 2'b00;
         rs1_sync_reg <= 2'b00;
         dis_prev_reg <= 1'b1;
         rs0_prev_reg <= 1'b0;
         rs1_prev_reg <= 1'b0;
      end else begin
         dis_sync_reg <= {dis_sync_reg[0], LASER_OFF_REQ};
         rs0_sync_reg <= {rs0_sync_reg[0], RECEIVE_BANDWIDTH_SELECT};
         rs1_sync_reg <= {rs1_sync_reg[0], TRANSMIT_BANDWIDTH_SELECT};
         dis_prev_reg <= dis_s;
         rs0_prev_reg <= rs0_s;
         rs1_prev_reg <= rs1_s;
      end
   end

   // ==========================================================
   // start-up timer; the management-ready timer is never loaded, so it stays idle
   deadline_timer u_mgmt (
      .clk(CLK),
      .rst(RST),
      .load(1'b0),
      .count(MGMT_CYCLES),
      .busy(mgmt_busy),
      .done(mgmt_done)
   );

   // start timer reloads on reset release, enable during start, recovery
   deadline_timer u_start (
      .clk(CLK),
      .rst(RST),
      .load((state_reg == ST_START && dis_fall) ||
            (state_reg == ST_FAULT && dis_fall && !TX_FAULT)),
      .count(START_CYCLES),
      .busy(start_busy),
      .done(start_done)
   );

   // ==========================================================
   // disable hold counter for fault reset width
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         hold_cnt_reg <= 32'h0000_0000;
      end else if (!dis_s) begin
         hold_cnt_reg <= 32'h0000_0000;
      end else if (hold_cnt_reg < RESET_CYCLES) begin
         hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
      end
   end

   // ==========================================================
   // transmitter state; power level II and cooled paths absent
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_START;
         LASER_ON <= 1'b0;
         OPERATIONAL <= 1'b0;
         off_cnt_reg <= 32'h0000_0000;
         on_cnt_reg <= 32'h0000_0000;
         ramping_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_START: begin
               // laser stays dark while disabled or starting
               if (!start_busy && !dis_s && !mgmt_busy) begin
                  state_reg <= ST_RUN;
                  LASER_ON <= 1'b1;
                  OPERATIONAL <= 1'b1;
               end else if (start_done && !dis_s) begin
                  state_reg <= ST_RUN;
                  LASER_ON <= 1'b1;
                  OPERATIONAL <= 1'b1;
               end
            end
            ST_RUN: begin
               if (TX_FAULT) begin
                  state_reg <= ST_FAULT;
                  LASER_ON <= 1'b0;
                  OPERATIONAL <= 1'b0;
               end else if (dis_s) begin
                  // turn off well inside the deadline
                  state_reg <= ST_OFF;
                  LASER_ON <= 1'b0;
                  off_cnt_reg <= 32'h0000_0000;
               end else if (ramping_reg) begin
                  on_cnt_reg <= on_cnt_reg + 32'h0000_0001;
                  if (on_cnt_reg >= ON_CYCLES - 32'h0000_0001) begin
                     ramping_reg <= 1'b0;
                  end
               end
            end
            ST_OFF: begin
               off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
               if (fault_cond && !TX_FAULT) begin
                  state_reg <= ST_OFF;
               end
               if (dis_fall) begin
                  state_reg <= ST_RUN;
                  LASER_ON <= 1'b1;
                  ramping_reg <= 1'b1;
                  on_cnt_reg <= 32'h0000_0000;
               end
            end
            ST_FAULT: begin
               // recovery starts on release after a valid reset;
               // a fault still standing is flagged again once running
               if (dis_fall && !TX_FAULT) begin
                  state_reg <= ST_START;
               end
            end
            default: begin
               state_reg <= ST_START;
               LASER_ON <= 1'b0;
               OPERATIONAL <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // fault detect and latch
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         TX_FAULT <= 1'b0;
         flt_cnt_reg <= 32'h0000_0000;
      end else begin
         // a detection counts cycles while the fault stands
         if (fault_cond && flt_cnt_reg < FAULT_CYCLES) begin
            flt_cnt_reg <= flt_cnt_reg + 32'h0000_0001;
         end else if (!fault_cond) begin
            flt_cnt_reg <= 32'h0000_0000;
         end
         if (fault_cond && OPERATIONAL &&
             flt_cnt_reg >= FAULT_CYCLES / 32'h0000_0002) begin
            TX_FAULT <= 1'b1;
         end else if (fault_reset) begin
            TX_FAULT <= 1'b0;
         end
      end
   end

   // ==========================================================
   // signal-lost flag, filtered at half the deadline
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         RX_SIGNAL_LOST <= 1'b1;
         los_state_reg <= 1'b1;
         los_cnt_reg <= 32'h0000_0000;
      end else if (sig_present == los_state_reg) begin
         // disagreement: count toward a flip
         if (los_cnt_reg >= LOS_CYCLES / 32'h0000_0002) begin
            los_state_reg <= ~sig_present;
            RX_SIGNAL_LOST <= ~sig_present;
            los_cnt_reg <= 32'h0000_0000;
         end else begin
            los_cnt_reg <= los_cnt_reg + 32'h0000_0001;
         end
      end else begin
         los_cnt_reg <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // rate select settle; outputs follow after settle window
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         RX_HIGH_BW <= 1'b0;
         TX_HIGH_BW <= 1'b0;
         rate_busy_reg <= 1'b0;
         rate_cnt_reg <= 32'h0000_0000;
      end else if (rate_chg) begin
         rate_busy_reg <= 1'b1;
         rate_cnt_reg <= 32'h0000_0000;
      end else if (rate_busy_reg) begin
         rate_cnt_reg <= rate_cnt_reg + 32'h0000_0001;
         // short settle keeps both modes inside deadline
         if (rate_cnt_reg >= (fc_mode ? RATE_FC_CYCLES :
                              RATE_NFC_CYCLES) / 32'h0000_0002) begin
            rate_busy_reg <= 1'b0;
            RX_HIGH_BW <= rs0_s;
            TX_HIGH_BW <= rs1_s;
         end
      end
   end

   // ==========================================================
   // management readiness after power-up
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         MGMT_READY <= 1'b0;
      end else if (!mgmt_busy) begin
         MGMT_READY <= 1'b1;
      end
   end

   // ==========================================================
   // interrupt events
   assign ev_set[`EV_FAULT] = fault_cond & OPERATIONAL & ~TX_FAULT &
                              (flt_cnt_reg >= FAULT_CYCLES / 32'h0000_0002);
   assign ev_set[`EV_LOS_ON] = (sig_present == los_state_reg) &
                               ~sig_present &
                               (los_cnt_reg >= LOS_CYCLES / 32'h0000_0002);
   assign ev_set[`EV_LOS_OFF] = (sig_present == los_state_reg) &
                                sig_present &
                                (los_cnt_reg >= LOS_CYCLES / 32'h0000_0002);
   assign ev_set[`EV_READY] = (state_reg == ST_START) & ~start_busy &
                              ~dis_s & ~mgmt_busy;
   assign ev_set[`EV_RATE] = rate_busy_reg & ~rate_chg &
                             (rate_cnt_reg >= (fc_mode ? RATE_FC_CYCLES :
                              RATE_NFC_CYCLES) / 32'h0000_0002);

   // sticky status, set beats clear
   genvar gi;
   generate
      for (gi = 0; gi < `EV_N; gi = gi + 1) begin : g_ev
         always @(posedge CLK or posedge RST) begin
            if (RST) begin
               ev_stat_reg[gi] <= 1'b0;
            end else if (ev_set[gi]) begin
               ev_stat_reg[gi] <= 1'b1;
            end else if (apb_wr && PADDR == `ADDR_IRQ_CLR &&
                         PWDATA[gi]) begin
               ev_stat_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // apb slave: no wait states, reads latched in setup
   always @* begin
      case (PADDR)
         `ADDR_CTRL: rd_mux = ctrl_reg;
         `ADDR_STAT: rd_mux = {22'h000000, rate_busy_reg, MGMT_READY,
                               OPERATIONAL, LASER_ON, TX_HIGH_BW,
                               RX_HIGH_BW, RX_SIGNAL_LOST, TX_FAULT,
                               state_reg[3], dis_s};
         `ADDR_IRQ_STAT: rd_mux = {27'h0000000, ev_stat_reg};
         `ADDR_IRQ_EN: rd_mux = {27'h0000000, ev_en_reg};
         `ADDR_IRQ_CLR: rd_mux = 32'h0000_0000;
         `ADDR_ID: rd_mux = `ID_VALUE;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
         ctrl_reg <= `CTRL_RESET;
         ev_en_reg <= {`EV_N{1'b0}};
         IRQ <= 1'b0;
      end else begin
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & (PADDR > `ADDR_ID);
         if (apb_rd) begin
            PRDATA <= rd_mux;
         end
         if (apb_wr && PADDR == `ADDR_CTRL) begin
            ctrl_reg <= {29'h00000000, PWDATA[2:0]};
         end
         if (apb_wr && PADDR == `ADDR_IRQ_EN) begin
            ev_en_reg <= PWDATA[`EV_N-1:0];
         end
         IRQ <= |(ev_stat_reg & ev_en_reg);
      end
   end
endmodule // optmod_ctrl

// ===== optmod_ctrl_props.sv
// Purpose: timing checks on the optical module pins
// Assumes: one clock, RST asynchronous active high
// Notes: fault and signal causes seen as control writes
`timescale 1ns/10ps
`include "optmod_defines.vh"
module optmod_ctrl_props #(
   parameter int ON_CYCLES = 40,
   parameter int FAULT_CYCLES = 40,
   parameter int RATE_NFC_CYCLES = 60,
   parameter int LOS_CYCLES = 40,
   parameter int MGMT_CYCLES = 40,
   parameter int RESET_CYCLES = 8
) (
   input wire CLK,
   input wire RST,
   input wire LASER_OFF_REQ,
   input wire RECEIVE_BANDWIDTH_SELECT,
   input wire TRANSMIT_BANDWIDTH_SELECT,
   input wire TX_FAULT,
   input wire RX_SIGNAL_LOST,
   input wire LASER_ON,
   input wire MGMT_READY,
   input wire OPERATIONAL,
   input wire RX_HIGH_BW,
   input wire TX_HIGH_BW,
   input wire IRQ,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR
);
// ==========================================
// pin run lengths and time since reset
int hi_cnt;
int last_hi;
int up_cnt;
wire wr_ctrl = PSEL && PENABLE && PREADY && PWRITE &&
   PADDR == `ADDR_CTRL;
// a mid-run reset restarts every count
always @(posedge CLK or posedge RST) begin
   if (RST) begin
      hi_cnt <= 0;
      last_hi <= 0;
      up_cnt <= 0;
   end else begin
      hi_cnt <= LASER_OFF_REQ ? hi_cnt + 1 : 0;
      if (!LASER_OFF_REQ && hi_cnt != 0) last_hi <= hi_cnt;
      if (up_cnt < MGMT_CYCLES) up_cnt <= up_cnt + 1;
   end
end
// ==========================================
// assertions
default clocking @(posedge CLK); endclocking
default disable iff (RST);
AST_LASER_OFF: assert property (
   $rose(LASER_OFF_REQ) ##1 LASER_OFF_REQ[*5] |-> !LASER_ON)
   else $error("laser on after off request");
AST_LASER_ON: assert property (
   $fell(LASER_OFF_REQ) && OPERATIONAL && !TX_FAULT
   |-> ##[1:ON_CYCLES] LASER_ON) else $error("laser late");
AST_MGMT: assert property (
   up_cnt == MGMT_CYCLES |-> MGMT_READY) else $error("mgmt late");
AST_FAULT_ON: assert property (
   wr_ctrl && PWDATA[1] && OPERATIONAL && !LASER_OFF_REQ
   |-> ##[1:FAULT_CYCLES] TX_FAULT) else $error("fault flag late");
AST_FAULT_CLR: assert property (
   $fell(TX_FAULT) |-> hi_cnt >= RESET_CYCLES || last_hi >= RESET_CYCLES)
   else $error("fault cleared by short pulse");
AST_FAULT_HOLD: assert property (
   (!LASER_OFF_REQ)[*6] ##0 TX_FAULT |=> TX_FAULT)
   else $error("fault flag dropped");
AST_RATE_RX: assert property (
   $changed(RECEIVE_BANDWIDTH_SELECT) |-> ##[1:RATE_NFC_CYCLES]
   RX_HIGH_BW == RECEIVE_BANDWIDTH_SELECT) else $error("rx rate late");
AST_RATE_TX: assert property (
   $changed(TRANSMIT_BANDWIDTH_SELECT) |-> ##[1:RATE_NFC_CYCLES]
   TX_HIGH_BW == TRANSMIT_BANDWIDTH_SELECT) else $error("tx rate late");
AST_LOS_ON: assert property (
   wr_ctrl && !PWDATA[2] && !RX_SIGNAL_LOST
   |-> ##[1:LOS_CYCLES] RX_SIGNAL_LOST) else $error("lost flag late");
AST_LOS_OFF: assert property (
   wr_ctrl && PWDATA[2] && RX_SIGNAL_LOST
   |-> ##[1:LOS_CYCLES] !RX_SIGNAL_LOST) else $error("lost flag stuck");
// main scenarios reached
CV_FAULT: cover property ($rose(TX_FAULT));
CV_LOS: cover property ($fell(RX_SIGNAL_LOST));
CV_ERR: cover property (PREADY && PSLVERR);
endmodule // optmod_ctrl_props

// ===== optmod_ctrl_tb.sv
// Purpose: self-checking bench for optmod_ctrl
// Assumes: 100 MHz clock, deadlines shortened by parameter
// Notes: wait bounds are the shortened deadlines, some plus slack, or a few cycles
`timescale 1ns/10ps
`include "optmod_defines.vh"
module optmod_ctrl_tb;
// ==========================================
// fc and non-fc settle times differ so a mix-up shows
localparam int t_start = 40;
localparam int t_fault = 40;
localparam int t_on = 40;
localparam int t_off = 40;
localparam int t_rfc = 20;
localparam int t_rnfc = 60;
localparam int t_los = 40;
localparam int t_rst = 8;
logic clk = 1'b0;
logic rst = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0000_0000;
wire off_req, rx_sel, tx_sel, pready, pslverr;
wire tx_fault, los, laser_on, mgmt_ready, oper, rx_bw, tx_bw, irq;
wire [31:0] prdata;
logic [31:0] rd;
logic err;
int fail_count = 0;
int samples_checked = 0;
int cycles = 0;
int exp_ctrl;
int q[$];
optmod_ctrl #(
   .START_CYCLES(t_start), .MGMT_CYCLES(t_start), .FAULT_CYCLES(t_fault),
   .ON_CYCLES(t_on), .RATE_NFC_CYCLES(t_rnfc), .RATE_FC_CYCLES(t_rfc),
   .OFF_CYCLES(t_off), .LOS_CYCLES(t_los), .RESET_CYCLES(t_rst)
) dut (
   .CLK(clk), .RST(rst), .LASER_OFF_REQ(off_req),
   .RECEIVE_BANDWIDTH_SELECT(rx_sel), .TRANSMIT_BANDWIDTH_SELECT(tx_sel),
   .TX_FAULT(tx_fault), .RX_SIGNAL_LOST(los), .LASER_ON(laser_on),
   .MGMT_READY(mgmt_ready), .OPERATIONAL(oper), .RX_HIGH_BW(rx_bw),
   .TX_HIGH_BW(tx_bw), .IRQ(irq), .PSEL(psel), .PENABLE(penable),
   .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
   .PREADY(pready), .PSLVERR(pslverr)
);
host_pins host (.clk(clk), .off_req(off_req), .rx_sel(rx_sel),
   .tx_sel(tx_sel));
// ==========================================
// clock, hang limit, compares
initial forever #5 clk = ~clk;
always @(posedge clk) begin
   cycles++;
   if (cycles == 5000) begin
      fail_count++;
      final_report();
   end
end
task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
   samples_checked++;
   if (got !== exp) begin
      fail_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
   end
endtask
function automatic logic sig(input int s);
   case (s)
      0: return laser_on;
      1: return tx_fault;
      2: return los;
      3: return oper;
      4: return mgmt_ready;
      5: return rx_bw;
      6: return tx_bw;
      default: return irq;
   endcase
endfunction
// bounded wait; a late level shows as a mismatch
task automatic wait_sig(input int s, input logic v, input int lim);
   int n;
   n = 0;
   while (sig(s) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
   end
   chk_word({31'h0, sig(s)}, {31'h0, v});
endtask
// one apb transfer; request held until pready is seen
task automatic apb(input logic w, input logic [11:0] a,
   input logic [31:0] d);
   @(posedge clk);
   psel <= 1'b1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge clk);
   penable <= 1'b1;
   do @(posedge clk); while (pready !== 1'b1);
   rd = prdata;
   err = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
   #1;
endtask
task automatic final_report();
   $display("checked %0d mismatches %0d", samples_checked, fail_count);
   if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
   else
      $display("CHECKS NOT OK");
   $finish;
endtask
// ==========================================
// main sequence
initial begin
   void'($urandom(32'he73a));
   @(posedge clk);
   #1;
   chk_word({31'h0, los}, 32'h1);
   repeat (5) @(posedge clk);
   rst <= 1'b0;
   wait_sig(4, 1'b1, t_start);
   wait_sig(3, 1'b1, t_start);
   wait_sig(0, 1'b1, t_start);
   // register map, unmapped place refused
   apb(1'b0, `ADDR_ID, 32'h0);
   chk_word(rd, `ID_VALUE);
   apb(1'b0, `ADDR_CTRL, 32'h0);
   chk_word(rd, `CTRL_RESET);
   apb(1'b0, 12'h018, 32'h0);
   chk_word({rd[31:1], err}, 32'h1);
   // signal back and lost again, interrupt raised, cleared, masked
   exp_ctrl = 5;
   apb(1'b1, `ADDR_IRQ_EN, 32'h4);
   apb(1'b1, `ADDR_CTRL, exp_ctrl);
   wait_sig(2, 1'b0, t_los);
   wait_sig(7, 1'b1, 3);
   apb(1'b0, `ADDR_CTRL, 32'h0);
   chk_word(rd, exp_ctrl);
   apb(1'b1, `ADDR_IRQ_CLR, 32'h4);
   wait_sig(7, 1'b0, 3);
   apb(1'b1, `ADDR_IRQ_EN, 32'h0);
   exp_ctrl = 1;
   apb(1'b1, `ADDR_CTRL, exp_ctrl);
   wait_sig(2, 1'b1, t_los);
   apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
   chk_word(rd & 32'h6, 32'h2);
   chk_word({31'h0, irq}, 32'h0);
   // fault, refused short reset, reassertion, recovery
   exp_ctrl = 7;
   apb(1'b1, `ADDR_CTRL, exp_ctrl);
   wait_sig(1, 1'b1, t_fault);
   wait_sig(0, 1'b0, 4);
   host.pulse(t_rst - 4);
   repeat (6) @(posedge clk);
   #1;
   chk_word({31'h0, tx_fault}, 32'h1);
   host.pulse(t_rst + 6);
   wait_sig(1, 1'b0, 6);
   wait_sig(1, 1'b1, t_start + t_fault);
   exp_ctrl = 5;
   apb(1'b1, `ADDR_CTRL, exp_ctrl);
   host.pulse(t_rst + 6);
   wait_sig(1, 1'b0, 6);
   // recovery runs the start timer after the synchronised release
   wait_sig(3, 1'b1, t_start + 8);
   wait_sig(0, 1'b1, t_start + 8);
   // laser off and on in normal operation
   host.set_off(1'b1);
   wait_sig(0, 1'b0, t_off);
   host.set_off(1'b0);
   wait_sig(0, 1'b1, t_on);
   // random rate selects, fc mode then non-fc mode
   for (int m = 1; m >= 0; m--) begin
      exp_ctrl = m + 4;
      apb(1'b1, `ADDR_CTRL, exp_ctrl);
      for (int i = 0; i < 4; i++) begin
         q.push_back($urandom % 4);
         host.set_sel(q[0][0], q[0][1]);
         wait_sig(5, q[0][0], m ? t_rfc : t_rnfc);
         wait_sig(6, q[0][1], m ? t_rfc : t_rnfc);
         void'(q.pop_front());
      end
   end
   final_report();
end
endmodule // optmod_ctrl_tb
bind optmod_ctrl optmod_ctrl_props #(
   .ON_CYCLES(ON_CYCLES), .FAULT_CYCLES(FAULT_CYCLES),
   .RATE_NFC_CYCLES(RATE_NFC_CYCLES), .LOS_CYCLES(LOS_CYCLES),
   .MGMT_CYCLES(MGMT_CYCLES), .RESET_CYCLES(RESET_CYCLES)
) props (
   .CLK(CLK), .RST(RST), .LASER_OFF_REQ(LASER_OFF_REQ),
   .RECEIVE_BANDWIDTH_SELECT(RECEIVE_BANDWIDTH_SELECT),
   .TRANSMIT_BANDWIDTH_SELECT(TRANSMIT_BANDWIDTH_SELECT),
   .TX_FAULT(TX_FAULT), .RX_SIGNAL_LOST(RX_SIGNAL_LOST),
   .LASER_ON(LASER_ON), .MGMT_READY(MGMT_READY),
   .OPERATIONAL(OPERATIONAL), .RX_HIGH_BW(RX_HIGH_BW),
   .TX_HIGH_BW(TX_HIGH_BW), .IRQ(IRQ), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR)
);

// ===== optmod_defines.vh
// Purpose: constants for the optical module control/status block
// Assumes: 100 MHz clock, 32-bit APB register words
// Notes: times kept in their printed units, counts derived from them
`ifndef OPTMOD_DEFINES_VH
`define OPTMOD_DEFINES_VH

// ==========================================================
// clock and deadlines
`define CLK_MHZ 100
`define T_OFF_US 100
`define T_ON_US 2000
`define T_MGMT_US 300000
`define T_START_US 300000
`define T_FAULT_US 1000
`define T_RESET_US 10
`define T_RATE_FC_US 500
`define T_RATE_NFC_US 10000
`define T_LOS_US 100
// deadline cycles: time in us times clock in MHz, exact
`define CYC_OFF (`T_OFF_US * `CLK_MHZ)
`define CYC_ON (`T_ON_US * `CLK_MHZ)
`define CYC_MGMT (`T_MGMT_US * `CLK_MHZ)
`define CYC_START (`T_START_US * `CLK_MHZ)
`define CYC_FAULT (`T_FAULT_US * `CLK_MHZ)
`define CYC_RESET (`T_RESET_US * `CLK_MHZ)
`define CYC_RATE_FC (`T_RATE_FC_US * `CLK_MHZ)
`define CYC_RATE_NFC (`T_RATE_NFC_US * `CLK_MHZ)
`define CYC_LOS (`T_LOS_US * `CLK_MHZ)
`define CNT_W 32

// ==========================================================
// register map (byte addresses)
`define ADDR_CTRL 12'h000
`define ADDR_STAT 12'h004
`define ADDR_IRQ_STAT 12'h008
`define ADDR_IRQ_EN 12'h00c
`define ADDR_IRQ_CLR 12'h010
`define ADDR_ID 12'h014
// control bit positions
`define CTRL_FC 0
`define CTRL_FAULT_IN 1
`define CTRL_SIG_IN 2
`define CTRL_RESET 32'h0000_0001
// event bit positions
`define EV_FAULT 0
`define EV_LOS_ON 1
`define EV_LOS_OFF 2
`define EV_READY 3
`define EV_RATE 4
`define EV_N 5
`define ID_VALUE 32'h0000_5a01 // arbitrary value
`endif
